// File: frt_pkg.sv
// Package for the free-running tick timer: widths, bit positions, timing.
// Assumes the system clock runs at 10 MHz.
package frt_pkg;
  // Clock period and tick period in nanoseconds.
  localparam int FRT_CLK_PERIOD_NS = 100;
  localparam int FRT_TICK_PERIOD_NS = 1000;
  // Clock cycles per one-microsecond tick.
  localparam int FRT_TICK_CYCLES = FRT_TICK_PERIOD_NS / FRT_CLK_PERIOD_NS;
  // Counter width and split of the firmware view.
  localparam int FRT_CNT_W = 12;
  localparam int FRT_LOW_W = 8;
  localparam int FRT_HIGH_W = 4;
  // Counter bits that source the two periodic requests.
  localparam int FRT_FAST_BIT = 6;
  localparam int FRT_SLOW_BIT = 9;
  // Reset values.
  localparam logic [11:0] FRT_CNT_RST = 12'h000;
  localparam logic [3:0] FRT_HOLD_RST = 4'h0;
endpackage

// File: frt_tick_div.sv
// Divider that turns the system clock into a one-cycle tick enable.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module frt_tick_div #(
  parameter int DIV = 10
) (
  input wire logic clk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  output logic tick // One-cycle pulse every DIV cycles.
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;

  initial
  begin
    if (DIV < 2)
      $error("frt_tick_div needs DIV of at least 2.");
  end

  // Count up through the period and pulse at its end.
  always_comb
  begin
    next_tick = (cnt == LAST);
    next_cnt = next_tick ? '0 : cnt + 1'b1;
  end

  // The pulse is registered so that it leaves straight from a flip-flop.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// File: frt_timer.sv
// Free-running 12-bit microsecond timer with two periodic requests and a
// coherent low/high read path. Assumes firmware reads arrive as one-cycle
// strobes from logic on the same clock, and that an interrupt controller
// consumes the one-cycle request pulses.
`timescale 1ns/1ps
// Function
// - Twelve-bit counter increments on each one-microsecond tick.
// - Requests derive from counter bit 6 and counter bit 9.
// - Request pulses only on rising source bit, and only when enabled.
// - Reading the low byte copies upper four bits into holding register.
// - Reading the high nibble returns the holding register, not live count.
module frt_timer
  import frt_pkg::*;
#(
  parameter int TICK_CYCLES = frt_pkg::FRT_TICK_CYCLES
) (
  input wire logic clk, // System clock, 10 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic rd_low, // One-cycle strobe: firmware reads low byte.
  input wire logic rd_high, // One-cycle strobe: firmware reads high nibble.
  input wire logic fast_en, // Enable for the 128 us request.
  input wire logic slow_en, // Enable for the 1.024 ms request.
  output logic [frt_pkg::FRT_LOW_W-1:0] rd_data, // Read data, valid cycle after strobe.
  output logic rd_valid, // One-cycle pulse marking rd_data.
  output logic fast_irq, // One-cycle 128 us request pulse.
  output logic slow_irq, // One-cycle 1.024 ms request pulse.
  output logic [frt_pkg::FRT_CNT_W-1:0] count // Live count, for observation.
);
  import frt_pkg::*;

  logic tick;
  logic fast_prev;
  logic slow_prev;
  logic [FRT_HIGH_W-1:0] hold;
  logic [FRT_CNT_W-1:0] next_count;
  logic [FRT_HIGH_W-1:0] next_hold;
  logic [FRT_LOW_W-1:0] next_rd_data;
  logic next_rd_valid;
  logic next_fast_irq;
  logic next_slow_irq;

  initial
  begin
    if (FRT_LOW_W + FRT_HIGH_W != FRT_CNT_W)
      $error("frt_timer: low and high parts must cover the counter.");
  end

  // One-microsecond enable from the system clock.
  frt_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_div (
    .clk(clk),
    .rstn(rstn),
    .tick(tick)
  );

  // Counter and request edge detection. The previous source bits are counter
  // bits registered one cycle late, so a request is one cycle after the change.
  always_comb
  begin
    next_count = tick ? count + 1'b1 : count;
    next_fast_irq = fast_en && count[FRT_FAST_BIT] && !fast_prev;
    next_slow_irq = slow_en && count[FRT_SLOW_BIT] && !slow_prev;
  end

  // Read path. A simultaneous low and high read returns the low byte and
  // still captures the nibble; the high read is dropped and returns nothing.
  always_comb
  begin
    next_hold = hold;
    next_rd_data = rd_data;
    next_rd_valid = rd_low || rd_high;
    if (rd_low)
    begin
      next_hold = count[FRT_CNT_W-1:FRT_LOW_W];
      next_rd_data = count[FRT_LOW_W-1:0];
    end
    else if (rd_high)
      next_rd_data = {{(FRT_LOW_W-FRT_HIGH_W){1'b0}}, hold};
  end

  // All timer state except the tick divider registered here; outputs leave straight from flip-flops.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= FRT_CNT_RST;
      fast_prev <= 1'b0;
      slow_prev <= 1'b0;
      fast_irq <= 1'b0;
      slow_irq <= 1'b0;
      hold <= FRT_HOLD_RST;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      count <= next_count;
      fast_prev <= count[FRT_FAST_BIT];
      slow_prev <= count[FRT_SLOW_BIT];
      fast_irq <= next_fast_irq;
      slow_irq <= next_slow_irq;
      hold <= next_hold;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // count steps by one per tick
  property p_count_step;
    @(posedge clk) disable iff (!rstn)
      tick |=> count == $past(count) + 12'h001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_count_hold;
    @(posedge clk) disable iff (!rstn)
      !tick |=> $stable(count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved without tick");

  property p_wrap;
    @(posedge clk) disable iff (!rstn)
      (tick && count == 12'hfff) |=> count == 12'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap");

  property p_fast_rise;
    @(posedge clk) disable iff (!rstn)
      ($rose(count[FRT_FAST_BIT]) && fast_en) |=> fast_irq;
  endproperty
  a_fast_rise: assert property (p_fast_rise) else $error("fast request missed");

  // slow request only after bit 9 rose
  property p_slow_cause;
    @(posedge clk) disable iff (!rstn)
      slow_irq |-> $past(count[FRT_SLOW_BIT]) && !$past(slow_prev) && $past(slow_en);
  endproperty
  a_slow_cause: assert property (p_slow_cause) else $error("spurious slow request");

  property p_fast_cause;
    @(posedge clk) disable iff (!rstn)
      fast_irq |-> $past(count[FRT_FAST_BIT]) && !$past(fast_prev) && $past(fast_en);
  endproperty
  a_fast_cause: assert property (p_fast_cause) else $error("spurious fast request");

  property p_capture;
    @(posedge clk) disable iff (!rstn)
      rd_low |=> hold == $past(count[11:8]) && rd_data == $past(count[7:0]);
  endproperty
  a_capture: assert property (p_capture) else $error("low read capture wrong");

  property p_high_read;
    @(posedge clk) disable iff (!rstn)
      (rd_high && !rd_low) |=> rd_data == {4'h0, $past(hold)} && rd_valid;
  endproperty
  a_high_read: assert property (p_high_read) else $error("high read not from hold");

  property p_slow_rise;
    @(posedge clk) disable iff (!rstn)
      ($rose(count[FRT_SLOW_BIT]) && slow_en) |=> slow_irq;
  endproperty
  a_slow_rise: assert property (p_slow_rise) else $error("slow request missed");

  property p_fast_once;
    @(posedge clk) disable iff (!rstn)
      fast_irq |=> !fast_irq;
  endproperty
  a_fast_once: assert property (p_fast_once) else $error("fast request too long");

  property p_slow_once;
    @(posedge clk) disable iff (!rstn)
      slow_irq |=> !slow_irq;
  endproperty
  a_slow_once: assert property (p_slow_once) else $error("slow request too long");

  property p_fast_masked;
    @(posedge clk) disable iff (!rstn)
      !fast_en |=> !fast_irq;
  endproperty
  a_fast_masked: assert property (p_fast_masked) else $error("fast request while disabled");

  property p_slow_masked;
    @(posedge clk) disable iff (!rstn)
      !slow_en |=> !slow_irq;
  endproperty
  a_slow_masked: assert property (p_slow_masked) else $error("slow request while disabled");

  property p_fast_fall;
    @(posedge clk) disable iff (!rstn)
      $fell(count[FRT_FAST_BIT]) |=> !fast_irq;
  endproperty
  a_fast_fall: assert property (p_fast_fall) else $error("fast request on fall");

  property p_slow_fall;
    @(posedge clk) disable iff (!rstn)
      $fell(count[FRT_SLOW_BIT]) |=> !slow_irq;
  endproperty
  a_slow_fall: assert property (p_slow_fall) else $error("slow request on fall");

  property p_hold_keep;
    @(posedge clk) disable iff (!rstn)
      !rd_low |=> $stable(hold);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("holding register moved");

  property p_rd_idle;
    @(posedge clk) disable iff (!rstn)
      !(rd_low || rd_high) |=> !rd_valid && $stable(rd_data);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data moved without read");
endmodule

// File: frt_timer_tb.sv
// Self-checking bench for the free-running tick timer.
// Assumes frt_pkg and frt_timer are compiled first; assertions live in the design.
`timescale 1ns/1ps
module frt_timer_tb;
  import frt_pkg::*;
  // A short tick keeps a full wrap of the counter near 8k cycles.
  localparam int TC = 2;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd_low = 1'b0;
  logic rd_high = 1'b0;
  logic fast_en = 1'b0;
  logic slow_en = 1'b0;
  logic [7:0] rd_data;
  logic rd_valid;
  logic fast_irq;
  logic slow_irq;
  logic [11:0] count;
  int errors = 0;
  int total_checks = 0;
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  frt_timer #(.TICK_CYCLES(TC)) u_dut (.clk(clk), .rstn(rstn), .rd_low(rd_low),
    .rd_high(rd_high), .fast_en(fast_en), .slow_en(slow_en), .rd_data(rd_data),
    .rd_valid(rd_valid), .fast_irq(fast_irq), .slow_irq(slow_irq), .count(count));
  // Compares a seen value with an expected one and counts both outcomes.
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One read strobe; the answer is fixed at one cycle, so no wait is needed.
  task automatic rd(input logic lo, output logic [7:0] d, output logic [11:0] c);
    @(negedge clk);
    c = count;
    rd_low = lo;
    rd_high = ~lo;
    @(negedge clk);
    rd_low = 1'b0;
    rd_high = 1'b0;
    chk("rd_valid", {11'h0, rd_valid}, 12'h001);
    d = rd_data;
  endtask
  // Exactly one count per TC cycles, regardless of tick phase.
  task automatic t_count();
    logic [11:0] c0;
    @(negedge clk);
    c0 = count;
    repeat (TC * 100) @(negedge clk);
    chk("count", count, c0 + 12'h064);
  endtask
  // One full wrap: counts pulses and checks each step, including fff to 000.
  task automatic t_irq(input logic fe, input logic se, input int nf, input int ns);
    int f;
    int s;
    logic [11:0] p;
    f = 0;
    s = 0;
    fast_en = fe;
    slow_en = se;
    repeat (2) @(negedge clk);
    p = count;
    repeat (4096 * TC)
    begin
      @(negedge clk);
      if (count !== p)
        chk("count_step", count, p + 12'h001);
      p = count;
      if (fast_irq === 1'b1)
      begin
        f++;
        chk("fast_src", {11'h0, count[6]}, 12'h001);
      end
      if (slow_irq === 1'b1)
      begin
        s++;
        chk("slow_src", {11'h0, count[9]}, 12'h001);
      end
    end
    chk("fast_pulses", f[11:0], nf[11:0]);
    chk("slow_pulses", s[11:0], ns[11:0]);
  endtask
  // Low read captures the upper nibble; a later high read returns the capture.
  task automatic t_read();
    logic [7:0] d;
    logic [11:0] c;
    logic [11:0] cx;
    for (int i = 0; i < 3; i++)
    begin
      rd(1'b1, d, c);
      chk("low_byte", {4'h0, d}, {4'h0, c[7:0]});
      repeat (TC * 300) @(negedge clk);
      rd(1'b0, d, cx);
      chk("high_nibble", {4'h0, d}, {8'h00, c[11:8]});
    end
  endtask
  // Mid-run reset clears count, requests and read path; counting restarts after.
  task automatic t_reset();
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    chk("rst_count", count, FRT_CNT_RST);
    chk("rst_irq", {10'h000, fast_irq, slow_irq}, 12'h000);
    chk("rst_read", {3'h0, rd_valid, rd_data}, 12'h000);
    rstn = 1'b1;
  endtask
  // Main sequence: reset, then each scenario in turn.
  initial
  begin
    repeat (20) @(negedge clk);
    chk("reset_count", count, FRT_CNT_RST);
    rstn = 1'b1;
    t_count();
    t_irq(1'b1, 1'b1, 32, 4);
    t_irq(1'b1, 1'b0, 32, 0);
    t_irq(1'b0, 1'b1, 0, 4);
    t_irq(1'b0, 1'b0, 0, 0);
    t_read();
    t_reset();
    t_count();
    end_sim();
  end
endmodule
